/* src/power_state_defines.svh */
// constants for the power state and wake controller
// assumes a 100 MHz clock; switch and wake inputs already synchronous
// Overview of operation
// - short press from off or sleep powers on
// - hold over six seconds forces soft-off
// - short press while on requests sleep
// - six wake sources resume from S3/S4/S5
// - pcie wake line wakes from S3/S4/S5
// - usb wakes S3, not after mechanical-off until another wake
// - usb wake S4/S5 needs firmware option
// - infrared remote wakes from S3/S4/S5
// - infrared remote blocked in S4/S5 when deep_sleep_off
// - lan wake-frame signal powers system up
// - programmed rtc alarm wakes from S5
// - after outage restore prior on/off state
// - S3: standby power only, amber indicator
// - wake from S3 resumes last working state
// - standby indicator lit while standby present
`ifndef POWER_STATE_DEFINES_SVH
`define POWER_STATE_DEFINES_SVH
`define CLK_FREQ_HZ 100000000
`define SHORT_PRESS_S 4
`define LONG_PRESS_S 6
`define DEBOUNCE_US 10
`define SHORT_PRESS_CYC (`SHORT_PRESS_S * `CLK_FREQ_HZ)
`define LONG_PRESS_CYC (`LONG_PRESS_S * `CLK_FREQ_HZ)
`define DEBOUNCE_CYC (`DEBOUNCE_US * (`CLK_FREQ_HZ / 1000000))
`endif

/* src/power_state_pkg.sv */
// types for the power state and wake controller
// no assumptions beyond a SystemVerilog compiler
package power_state_pkg;
    typedef enum logic [4:0] {
        PS_OFF = 5'h01,
        PS_ON = 5'h02,
        PS_S3 = 5'h04,
        PS_S4 = 5'h08,
        PS_S5 = 5'h10
    } pstate_t;
    // sleep request kind from operating system settings
    typedef enum logic [1:0] {
        SLP_S3 = 2'h0,
        SLP_S4 = 2'h1,
        SLP_S5 = 2'h2
    } sleep_kind_t;
endpackage : power_state_pkg

/* src/power_state_wake_controller.sv */
// power state tracker with power switch timing and wake collection
// assumes standby-powered clock; srst comes from ac application
`timescale 1ns/100ps
`default_nettype none
`include "power_state_defines.svh"
module power_state_wake_controller
    import power_state_pkg::*;
#(
    parameter int unsigned SHORT_CYC = `SHORT_PRESS_CYC,
    parameter int unsigned LONG_CYC = `LONG_PRESS_CYC,
    parameter int unsigned DEB_CYC = `DEBOUNCE_CYC
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic powerSwitch,
    input wire power_state_pkg::sleep_kind_t sleepKind,
    input wire logic osSleepReq,
    input wire logic rtcAlarm,
    input wire logic rtcAlarmArmed,
    input wire logic lanWake,
    input wire logic usbActivity,
    input wire logic usbWakeS45En,
    input wire logic pcieWake,
    input wire logic infrared_remote,
    input wire logic deep_sleep_off,
    input wire logic restoreEn,
    input wire logic lastWasOn,
    input wire logic standbyPresent,
    output logic mainPowerOn,
    output logic sleepReqOut,
    output logic ledPrimary,
    output logic ledSecondary,
    output logic standbyLed,
    output logic wakePulse,
    output power_state_pkg::pstate_t powerState
);
    import power_state_pkg::*;

    // behaviour notes for users of this block:
    // - all pin inputs are taken as already synchronous to clk
    // - the switch is believed only after DEB_CYC steady cycles, so
    //   every press and every release is seen that much later
    // - press length is judged on release, except the forced off,
    //   which fires while the switch is still held down
    // - wake sources are levels; one high cycle while resting is enough
    // - a wake source held high across a sleep request wakes the system
    //   again on the next edge; sources are expected to be pulses
    // - the sleep target is chosen by software through sleepKind; the
    //   switch only raises sleepReqOut and leaves the choice to it
    // - after srst every usb wake is refused until some other wake
    //   has brought the system up once
    // - the restore decision is taken once, on the first edge after srst

    ////////////////////////////////////////////////////////////////
    // shared decodes and limits

    // hold counter ceiling, so a switch stuck closed cannot wrap
    localparam logic [31:0] HOLD_MAX = 32'hFFFFFFFF;

    // working state: main rails up and primary lamp lit
    function automatic logic isWorking(input pstate_t st);
        return (st == PS_ON);
    endfunction : isWorking

    // suspend to ram: standby rail only, secondary lamp lit
    function automatic logic isSuspend(input pstate_t st);
        return (st == PS_S3);
    endfunction : isSuspend

    // disk and soft-off rest, where usb and infrared need extra gating
    function automatic logic isDeepRest(input pstate_t st);
        return (st == PS_S4) || (st == PS_S5);
    endfunction : isDeepRest

    // states a held switch may force down; off and s5 are already there
    function automatic logic canForceOff(input pstate_t st);
        return (st == PS_ON) || (st == PS_S3) || (st == PS_S4);
    endfunction : canForceOff

    ////////////////////////////////////////////////////////////////
    // switch debounce and hold timer
    logic debReg, debNext;
    logic [31:0] debCntReg, debCntNext;
    logic [31:0] holdCntReg, holdCntNext;
    logic longFiredReg, longFiredNext;
    logic shortPress, longPress;
    logic restoredReg, restoredNext;
    logic g3SeenReg, g3SeenNext;
    logic wakeHit;

    // input must hold steady for the debounce count before it is believed
    // a bounce inside the window restarts the count from zero
    always_comb
    begin
        debNext = debReg;
        debCntNext = '0;
        if (powerSwitch != debReg)
        begin
            debCntNext = debCntReg + 32'h1;
            if (debCntReg >= DEB_CYC - 1)
            begin
                debNext = powerSwitch;
                debCntNext = '0;
            end
        end
    end

    // hold counter saturates so a very long press never wraps
    always_comb
    begin
        holdCntNext = holdCntReg;
        longFiredNext = longFiredReg;
        shortPress = 1'b0;
        longPress = 1'b0;
        if (debReg)
        begin
            if (holdCntReg != HOLD_MAX)
                holdCntNext = holdCntReg + 32'h1;
            // longFiredReg keeps one hold from firing twice
            if (holdCntReg > LONG_CYC && !longFiredReg)
            begin
                longPress = 1'b1;
                longFiredNext = 1'b1;
            end
        end
        else
        begin
            // a release ends the hold; the counter clears for the next press
            // releases between four and six seconds do nothing
            shortPress = (holdCntReg != '0) && (holdCntReg < SHORT_CYC);
            holdCntNext = '0;
            longFiredNext = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            debReg <= 1'b0;
            debCntReg <= '0;
            holdCntReg <= '0;
            longFiredReg <= 1'b0;
        end
        else
        begin
            debReg <= debNext;
            debCntReg <= debCntNext;
            holdCntReg <= holdCntNext;
            longFiredReg <= longFiredNext;
        end
    end

    ////////////////////////////////////////////////////////////////
    // wake qualification, only looked at while not working
    logic rtcHit, usbHit, irHit;

    // per-source gating that depends on the resting state
    always_comb
    begin
        // an alarm that nobody programmed is treated as noise
        rtcHit = rtcAlarm && rtcAlarmArmed;
        // usb after a mechanical-off stays dead until the next real wake
        usbHit = usbActivity && !g3SeenReg;
        if (isDeepRest(powerState))
            usbHit = usbHit && usbWakeS45En;
        // infrared is muted in the deep low-power variant of s4/s5
        irHit = infrared_remote;
        if (isDeepRest(powerState) && deep_sleep_off)
            irHit = 1'b0;
    end

    // any qualified source while resting
    always_comb
    begin
        wakeHit = 1'b0;
        case (powerState)
            PS_S3, PS_S4, PS_S5:
                wakeHit = shortPress || rtcHit || lanWake || pcieWake
                    || usbHit || irHit;
            PS_OFF:
                wakeHit = shortPress;
            default:
                wakeHit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // state sequencer
    pstate_t stateNext;
    logic sleepReqNext, wakePulseNext;

    always_comb
    begin
        stateNext = powerState;
        sleepReqNext = 1'b0;
        wakePulseNext = 1'b0;
        restoredNext = 1'b1;
        g3SeenNext = g3SeenReg;
        if (!restoredReg)
        begin
            // one-shot decision after ac returns; no wake or press is
            // honoured on this edge, they would race the restore
            stateNext = (restoreEn && lastWasOn) ? PS_ON : PS_S5;
        end
        else if (longPress && canForceOff(powerState))
        begin
            // fail-safe off wins over any wake or sleep in the same cycle,
            // so a hung system can always be forced down from the panel
            stateNext = PS_S5;
        end
        else
        begin
            case (powerState)
                PS_ON:
                begin
                    // a short press only asks software; the target comes
                    // from sleepKind once software commits with osSleepReq
                    if (shortPress)
                        sleepReqNext = 1'b1;
                    if (osSleepReq)
                    begin
                        case (sleepKind)
                            SLP_S3: stateNext = PS_S3;
                            SLP_S4: stateNext = PS_S4;
                            default: stateNext = PS_S5;
                        endcase
                    end
                end
                PS_S3, PS_S4, PS_S5, PS_OFF:
                begin
                    // every rest returns to working; s3 context sits in ram,
                    // so this is the last working state
                    if (wakeHit)
                    begin
                        stateNext = PS_ON;
                        wakePulseNext = 1'b1;
                        g3SeenNext = 1'b0;
                    end
                end
                // unreachable with one-hot codes; recover to soft-off
                default:
                    stateNext = PS_S5;
            endcase
        end
    end

    // state registers; powerState leaves reset as off and is replaced by
    // the restore decision on the first edge after release
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            powerState <= PS_OFF;
            restoredReg <= 1'b0;
            g3SeenReg <= 1'b1; // ac just applied: a mechanical-off happened
            sleepReqOut <= 1'b0;
            wakePulse <= 1'b0;
        end
        else
        begin
            powerState <= stateNext;
            restoredReg <= restoredNext;
            g3SeenReg <= g3SeenNext;
            sleepReqOut <= sleepReqNext;
            wakePulse <= wakePulseNext;
        end
    end

    ////////////////////////////////////////////////////////////////
    // power rail and indicator drive
    // taken from the next state, so rails and lamps move on the same
    // edge as powerState rather than trailing it by one cycle
    logic mainPowerNext, ledPrimaryNext, ledSecondaryNext, standbyLedNext;

    // lamp and rail decode
    always_comb
    begin
        mainPowerNext = isWorking(stateNext);
        ledPrimaryNext = isWorking(stateNext);
        // single-colour panels wire only the primary lamp, so s3 looks dark
        ledSecondaryNext = isSuspend(stateNext);
        // stays lit while the system looks off, as a warning to unplug
        standbyLedNext = standbyPresent;
    end

    // output registers, straight to the pins
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mainPowerOn <= 1'b0;
            ledPrimary <= 1'b0;
            ledSecondary <= 1'b0;
            standbyLed <= 1'b0;
        end
        else
        begin
            mainPowerOn <= mainPowerNext;
            ledPrimary <= ledPrimaryNext;
            ledSecondary <= ledSecondaryNext;
            standbyLed <= standbyLedNext;
        end
    end
endmodule : power_state_wake_controller
`default_nettype wire

/* test/panel_switch_model.sv */
// front panel switch, held closed for a set number of cycles
// driven on the falling clock edge like the rest of the bench
`timescale 1ns/100ps
`default_nettype none
module panel_switch_model (
    input wire logic clk,
    output logic powerSwitch
);
    initial powerSwitch = 1'b0;
    // no bounce modelled; the debounce then only adds delay
    task automatic press(input int n);
        @(negedge clk);
        powerSwitch = 1'b1;
        repeat (n) @(negedge clk);
        powerSwitch = 1'b0;
    endtask : press
endmodule : panel_switch_model
`default_nettype wire

/* test/power_state_wake_controller_checker.sv */
// checker on the controller's state and indications
// bound onto the controller top
`timescale 1ns/100ps
`default_nettype none
module power_state_wake_controller_checker
    import power_state_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic restoreEn,
    input wire logic lastWasOn,
    input wire logic rtcAlarm,
    input wire logic rtcAlarmArmed,
    input wire logic lanWake,
    input wire logic pcieWake,
    input wire logic infrared_remote,
    input wire logic standbyPresent,
    input wire logic mainPowerOn,
    input wire logic ledSecondary,
    input wire logic standbyLed,
    input wire logic wakePulse,
    input wire power_state_pkg::pstate_t powerState
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    wire logic slp = powerState inside {PS_S3, PS_S4, PS_S5};
    ////////////////////////////////////////
    // wakes act on the edge after the source is seen
    AST_PCIE: assert property (slp && pcieWake |=> powerState == PS_ON)
        else $error("pcie wake missed");
    AST_LAN: assert property (slp && lanWake |=> powerState == PS_ON)
        else $error("lan wake missed");
    AST_RTC: assert property (powerState == PS_S5 && rtcAlarm && rtcAlarmArmed |=> powerState == PS_ON)
        else $error("alarm wake missed");
    AST_IR: assert property (powerState == PS_S3 && infrared_remote |=> powerState == PS_ON)
        else $error("remote wake missed");
    AST_PULSE: assert property (wakePulse |-> powerState == PS_ON ##1 !wakePulse)
        else $error("wake pulse wrong");
    // rails and lamps move on the same edge as the state
    AST_S3LED: assert property (
        powerState == PS_S3 |-> ledSecondary && !mainPowerOn)
        else $error("sleep indication wrong");
    AST_STBY: assert property (!$past(srst) |-> standbyLed == $past(standbyPresent))
        else $error("standby lamp wrong");
    AST_RESTORE: assert property (
        $fell(srst) |=> powerState == ($past(restoreEn && lastWasOn) ? PS_ON : PS_S5))
        else $error("restore state wrong");
    cover property (slp && pcieWake);
    cover property ($fell(srst));
    cover property (powerState == PS_S4 ##1 powerState == PS_ON);
endmodule : power_state_wake_controller_checker
`default_nettype wire

/* test/power_state_wake_controller_tb.sv */
// bench: switch timing, sleep entry and every wake source
// assumes shortened press counts: short 40, long 60, debounce 2
`timescale 1ns/100ps
`default_nettype none
module power_state_wake_controller_tb;
    import power_state_pkg::*;
    logic clk, srst, osSleepReq, usbS45, deep_sleep_off, restoreEn, lastWasOn;
    logic powerSwitch, standbyPresent, mainPowerOn, ledSecondary, standbyLed;
    logic wakePulse, sleepReqOut, ledPrimary, armed;
    logic [4:0] wk;
    sleep_kind_t sleepKind;
    pstate_t powerState;
    int nFail = 0;
    int checksDone = 0;
    int nReq = 0;
    int nWake = 0;
    panel_switch_model PSW (.clk(clk), .powerSwitch(powerSwitch));
    power_state_wake_controller #(.SHORT_CYC(40), .LONG_CYC(60), .DEB_CYC(2)) DUT (
        .clk(clk), .srst(srst), .powerSwitch(powerSwitch), .sleepKind(sleepKind),
        .osSleepReq(osSleepReq), .rtcAlarm(wk[0]), .rtcAlarmArmed(armed), .lanWake(wk[1]),
        .usbActivity(wk[2]), .usbWakeS45En(usbS45), .pcieWake(wk[3]),
        .infrared_remote(wk[4]), .deep_sleep_off(deep_sleep_off), .restoreEn(restoreEn),
        .lastWasOn(lastWasOn), .standbyPresent(standbyPresent), .mainPowerOn(mainPowerOn),
        .sleepReqOut(sleepReqOut), .ledPrimary(ledPrimary), .ledSecondary(ledSecondary),
        .standbyLed(standbyLed), .wakePulse(wakePulse), .powerState(powerState));
    ////////////////////////////////////////
    // clock, and counts of sleep requests and wake pulses
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (sleepReqOut === 1'b1) nReq++;
    always @(posedge clk) if (wakePulse === 1'b1) nWake++;
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic chk(input logic [4:0] exp, input logic [4:0] got);
        checksDone++;
        if (got !== exp)
        begin
            nFail++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    // state plus the rail and lamps that the rules tie to it
    task automatic chkState(input pstate_t exp);
        chk(exp, powerState);
        chk({2'h0, exp == PS_ON, exp == PS_ON, exp == PS_S3},
            {2'h0, mainPowerOn, ledPrimary, ledSecondary});
    endtask : chkState
    task automatic doReset(input logic keep, input pstate_t exp);
        restoreEn = keep;
        srst = 1'b1;
        cyc(5);
        srst = 1'b0;
        cyc(3);
        chkState(exp);
    endtask : doReset
    // one-cycle source pulse, enough since wakes act on the next edge
    task automatic wake(input int i, input pstate_t exp);
        wk[i] = 1'b1;
        cyc(1);
        wk[i] = 1'b0;
        cyc(2);
        chkState(exp);
    endtask : wake
    task automatic sleepTo(input sleep_kind_t k, input pstate_t exp);
        sleepKind = k;
        osSleepReq = 1'b1;
        cyc(1);
        osSleepReq = 1'b0;
        cyc(2);
        chkState(exp);
    endtask : sleepTo
    task automatic press(input int n, input pstate_t exp);
        PSW.press(n);
        cyc(6);
        chkState(exp);
    endtask : press
    // standby lamp follows the standby rail one cycle later
    task automatic standby(input logic v);
        standbyPresent = v;
        cyc(2);
        chk({4'h0, v}, {4'h0, standbyLed});
    endtask : standby
    task automatic endOfTest;
        $display("checks %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0)
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : endOfTest
    // the whole run is a few hundred cycles
    initial
    begin
        #100000;
        nFail++;
        endOfTest;
    end
    initial
    begin
        {srst, osSleepReq, usbS45, deep_sleep_off, restoreEn, wk} = '0;
        {lastWasOn, standbyPresent, armed} = 3'h7;
        sleepKind = SLP_S3;
        doReset(1'b0, PS_S5);
        usbS45 = 1'b1;
        wake(2, PS_S5);
        usbS45 = 1'b0;
        press(10, PS_ON);
        wake(1, PS_ON);
        press(10, PS_ON);
        chk(5'h01, 5'(nReq));
        sleepTo(SLP_S3, PS_S3);
        wake(2, PS_ON);
        sleepTo(SLP_S3, PS_S3);
        wake(3, PS_ON);
        sleepTo(SLP_S3, PS_S3);
        wake(4, PS_ON);
        sleepTo(SLP_S4, PS_S4);
        wake(2, PS_S4);
        deep_sleep_off = 1'b1;
        wake(4, PS_S4);
        deep_sleep_off = 1'b0;
        wake(4, PS_ON);
        sleepTo(SLP_S4, PS_S4);
        usbS45 = 1'b1;
        wake(2, PS_ON);
        press(50, PS_ON);
        press(70, PS_S5);
        armed = 1'b0;
        wake(0, PS_S5);
        armed = 1'b1;
        wake(0, PS_ON);
        sleepTo(SLP_S5, PS_S5);
        wake(1, PS_ON);
        chk(5'h08, 5'(nWake));
        standby(1'b0);
        standby(1'b1);
        doReset(1'b1, PS_ON);
        endOfTest;
    end
endmodule : power_state_wake_controller_tb
bind power_state_wake_controller power_state_wake_controller_checker CHK (.clk, .srst,
    .restoreEn, .lastWasOn, .rtcAlarm, .rtcAlarmArmed, .lanWake, .pcieWake, .infrared_remote,
    .standbyPresent, .mainPowerOn, .ledSecondary, .standbyLed, .wakePulse, .powerState);
`default_nettype wire
